// ==== fpi_pkg.sv ====
`default_nettype none

package fpi_pkg;

    // ------------------------------------------------------------
    // operand and result sizing
    // ------------------------------------------------------------
    localparam int DATA_W_DEF = 32;
    localparam int BUS_W_DEF = 32;
    localparam int LATENCY_DEF = 1;

    // ------------------------------------------------------------
    // operation codes, alphabetical from zero
    // ------------------------------------------------------------
    localparam int OPC_W = 2;
    localparam logic [OPC_W-1:0] OPC_ADD = 2'h0;
    localparam logic [OPC_W-1:0] OPC_EQ = 2'h1;
    localparam logic [OPC_W-1:0] OPC_GT = 2'h2;
    localparam logic [OPC_W-1:0] OPC_SUB = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_FLAG = 1'h0;

    // one pipeline slot: valid flag and the computed result
    typedef struct packed {
        logic vld;
        logic [BUS_W_DEF-1:0] data;
    } fpi_slot_s;

endpackage

`default_nettype wire

// ==== fpi_function_unit.sv ====
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - each input operand port has its own load strobe named after it.
// - a high load strobe marks its operand valid and the unit captures it into a register.
// - a high trigger load starts the selected operation on the trigger and stored operands.
// - because the unit has several operations it has an operation-code input.
// - the operation code is sampled together with the trigger load strobe.
// - operation codes are numbered alphabetically from zero.
// - reset is active low and clears operand, pipeline and result state.
// - global lock freezes all ongoing work until it is released.
// - the unit raises a lock request when its result is later than the static latency.
// - the lock request rises after the static count without data and holds until it arrives.
// - operand width follows DATA_W and result width follows BUS_W, both 32 by default.
// - the trigger port width is a separate address-width parameter for load-store use.
// - the unit has an extra port that leads outside the core.
module fpi_function_unit #(
    parameter int DATA_W = fpi_pkg::DATA_W_DEF,
    parameter int BUS_W = fpi_pkg::BUS_W_DEF,
    parameter int ADDR_W = fpi_pkg::DATA_W_DEF,
    parameter int LATENCY = fpi_pkg::LATENCY_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] t1data,
    input wire logic [fpi_pkg::OPC_W-1:0] t1opcode,
    input wire logic t1load,
    input wire logic [DATA_W-1:0] o1data,
    input wire logic o1load,
    output logic [BUS_W-1:0] r1data,
    input wire logic glock,
    output logic glock_req,
    input wire logic ext_ready
);

    // ------------------------------------------------------------
    // operation evaluation
    // ------------------------------------------------------------

    // computes one operation on operand 1 (a) and the trigger (b); compares give bit 0
    function automatic logic [BUS_W-1:0] fpi_eval(
        input logic [fpi_pkg::OPC_W-1:0] opc,
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b
    );
        logic [DATA_W-1:0] r;
        r = '0;
        unique case (opc)
            fpi_pkg::OPC_ADD: r = a + b;
            fpi_pkg::OPC_EQ: r = {{(DATA_W-1){1'b0}}, a == b};
            fpi_pkg::OPC_GT: r = {{(DATA_W-1){1'b0}}, a > b};
            fpi_pkg::OPC_SUB: r = a - b;
        endcase
        return BUS_W'(r);
    endfunction

    // ------------------------------------------------------------
    // operand capture and control terms
    // ------------------------------------------------------------
    logic [DATA_W-1:0] o1_reg;
    logic [DATA_W-1:0] o1_eff;
    logic [DATA_W-1:0] trig_val;
    logic [BUS_W-1:0] trig_res;
    logic [BUS_W-1:0] last_data;
    logic [LATENCY-1:0] vld;
    logic [BUS_W-1:0] pdata [LATENCY];
    logic arrived;
    logic ext_ok;
    logic stall_now;
    logic advance;
    logic retire;

    // operand 1 written in the same cycle as the trigger is used at once
    assign o1_eff = o1load ? o1data : o1_reg;
    assign trig_val = DATA_W'(t1data);
    assign trig_res = fpi_eval(t1opcode, o1_eff, trig_val);
    assign last_data = pdata[LATENCY-1];
    assign ext_ok = ext_ready | arrived;
    assign stall_now = vld[LATENCY-1] & ~ext_ok;
    assign advance = ~glock & ~stall_now;
    assign retire = advance & vld[LATENCY-1];

    // operand register, loaded by its own strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o1_reg <= '0;
        end else if (o1load && !glock) begin
            o1_reg <= o1data;
        end
    end

    // ------------------------------------------------------------
    // pipeline of fixed latency
    // ------------------------------------------------------------

    // stage 0 takes a triggered result; later stages shift on advance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vld[0] <= fpi_pkg::RST_FLAG;
            pdata[0] <= '0;
        end else if (advance) begin
            vld[0] <= t1load;
            if (t1load) begin
                pdata[0] <= trig_res;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi < LATENCY; gi++) begin : g_stage
            // one further delay stage
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    vld[gi] <= fpi_pkg::RST_FLAG;
                    pdata[gi] <= '0;
                end else if (advance) begin
                    vld[gi] <= vld[gi-1];
                    pdata[gi] <= pdata[gi-1];
                end
            end

            // each further stage copies its neighbour on advance
            a_stage_shift: assert property (@(posedge clk) disable iff (!rst_n)
                advance |=> vld[gi] == $past(vld[gi-1]) && pdata[gi] == $past(pdata[gi-1]))
                else $error("stage did not shift");
        end
    endgenerate

    // ------------------------------------------------------------
    // result and late-data handling
    // ------------------------------------------------------------

    // result holds until a new one retires
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r1data <= '0;
        end else if (retire) begin
            r1data <= last_data;
        end
    end

    // remembers that the outside release came while the core was locked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arrived <= fpi_pkg::RST_FLAG;
        end else if (retire) begin
            arrived <= 1'b0; // data seen at a retiring edge belongs to the leaving result
        end else if (vld[LATENCY-1] && ext_ready) begin
            arrived <= 1'b1;
        end
    end

    // lock request held while the retiring result is still missing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            glock_req <= fpi_pkg::RST_FLAG;
        end else begin
            glock_req <= stall_now;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_trig;
        t1load && !glock && !stall_now;
    endsequence

    sequence s_retire;
        retire;
    endsequence

    a_op1_capture: assert property (o1load && !glock |=> o1_reg == $past(o1data))
        else $error("operand not captured");
    a_op1_frozen: assert property (glock |=> $stable(o1_reg))
        else $error("operand changed under lock");
    a_trig_start: assert property (s_trig |=> vld[0])
        else $error("trigger did not start operation");
    a_add_value: assert property (s_trig ##0 (t1opcode == fpi_pkg::OPC_ADD)
        |=> pdata[0] == BUS_W'($past(trig_val) + $past(o1_eff)))
        else $error("add result wrong");
    a_sub_value: assert property (s_trig ##0 (t1opcode == fpi_pkg::OPC_SUB)
        |=> pdata[0] == BUS_W'($past(o1_eff) - $past(trig_val)))
        else $error("sub result wrong");
    a_eq_value: assert property (s_trig ##0 (t1opcode == fpi_pkg::OPC_EQ)
        |=> pdata[0] == BUS_W'($past(trig_val) == $past(o1_eff)))
        else $error("eq result wrong");
    a_result_update: assert property (s_retire |=> r1data == $past(last_data))
        else $error("result not delivered");
    a_result_hold: assert property (!retire |=> $stable(r1data))
        else $error("result changed without retire");
    a_lock_freeze: assert property (glock |=> $stable(vld) && $stable(r1data))
        else $error("pipeline moved under lock");
    a_lockreq_raise: assert property (vld[LATENCY-1] && !ext_ready && !arrived
        |=> glock_req)
        else $error("late result without lock request");
    a_lockreq_drop: assert property (vld[LATENCY-1] && ext_ready |=> !glock_req)
        else $error("lock request kept after data");

    // ------------------------------------------------------------
    // operand and trigger checks
    // ------------------------------------------------------------

    // a trigger met by lock or stall
    sequence s_held;
        t1load && !advance;
    endsequence

    // greater-than compares operand 1 against the trigger, unsigned
    a_gt_value: assert property (s_trig ##0 (t1opcode == fpi_pkg::OPC_GT)
        |=> pdata[0] == BUS_W'($past(o1_eff) > $past(trig_val)))
        else $error("gt result wrong");

    // compare operations leave every bit above bit 0 clear
    a_cmp_narrow: assert property (s_trig
        ##0 (t1opcode == fpi_pkg::OPC_EQ || t1opcode == fpi_pkg::OPC_GT)
        |=> pdata[0] < BUS_W'(2))
        else $error("compare result wider than one bit");

    // a same-cycle operand 1 write is used by the trigger it meets
    a_op1_bypass: assert property (s_trig ##0 o1load
        ##0 (t1opcode == fpi_pkg::OPC_ADD)
        |=> pdata[0] == BUS_W'($past(o1data) + $past(trig_val)))
        else $error("same-cycle operand not used");

    // an operand register moves only on its own strobe
    a_op1_keep: assert property (!o1load |=> $stable(o1_reg))
        else $error("operand changed without its strobe");

    // a refused trigger leaves the first stage untouched
    a_trig_refused: assert property (s_held
        |=> $stable(vld[0]) && $stable(pdata[0]))
        else $error("trigger taken while frozen");

    // a moving pipeline without a trigger starts nothing
    a_trig_none: assert property (advance && !t1load |=> !vld[0])
        else $error("operation started without trigger");

    // ------------------------------------------------------------
    // late-data checks
    // ------------------------------------------------------------

    // the retiring result still waits for its outside data
    sequence s_late;
        vld[LATENCY-1] && !ext_ready && !arrived;
    endsequence

    // the outside data for the retiring result is present
    sequence s_data_seen;
        vld[LATENCY-1] && ext_ready;
    endsequence

    // nothing waiting means no request
    a_req_idle: assert property (!vld[LATENCY-1] |=> !glock_req)
        else $error("lock request without a waiting result");

    // a result still missing on two edges keeps the request up
    a_req_kept: assert property (s_late ##1 s_late |=> glock_req)
        else $error("lock request dropped before data");

    // data seen under lock is remembered for the release
    a_data_kept: assert property (s_data_seen ##0 glock |=> arrived)
        else $error("outside data lost under lock");

    // the memory of the data lasts until its result retires
    a_data_hold: assert property (arrived && !retire |=> arrived)
        else $error("outside data memory lost early");

    // data present and no lock retires the waiting result at once
    a_data_retire: assert property (s_data_seen ##0 !glock
        |=> r1data == $past(last_data))
        else $error("result not delivered after data");

    // a stall without lock keeps the result output still
    a_stall_still: assert property (stall_now |=> $stable(r1data))
        else $error("result moved during stall");

    // ------------------------------------------------------------
    // helper count of edges the retiring result has waited
    // ------------------------------------------------------------

    logic [7:0] wait_len;

    // counts edges with a result parked in the last stage, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_len <= 8'h0;
        end else if (!vld[LATENCY-1] || retire) begin
            wait_len <= 8'h0;
        end else if (wait_len != 8'hff) begin
            wait_len <= wait_len + 8'h1;
        end
    end

    // the request comes only after the result has waited its turn
    a_req_after_wait: assert property (glock_req |-> wait_len != 8'h0)
        else $error("lock request before the static count passed");

endmodule

`default_nettype wire

// ==== fpi_gcu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// core control stand-in
// ------------------------------------------------------------
module fpi_global_control_unit_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic glock_req,
    input wire logic hold_lock,
    output logic glock
);
    // lock the core one edge after a request or a forced hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            glock <= 1'b0;
        end else begin
            glock <= glock_req | hold_lock;
        end
    end
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT(c) begin for (int k = 0; k < 20 && !(c); k++) cyc(1); \
    if (!(c)) begin n_errors++; test_done(); end end

module tb;
    typedef struct packed {
        logic [31:0] o1;
        logic [31:0] t1;
        logic [1:0] opc;
        logic [31:0] res;
    } fpi_row_s;
    logic clk = 1'b0, rst_n = 1'b0, t1load = 1'b0, o1load = 1'b0;
    logic hold_lock = 1'b0, ext_ready = 1'b1;
    logic [31:0] t1data = 32'h0, o1data = 32'h0, r1data;
    logic [fpi_pkg::OPC_W-1:0] t1opcode = 2'h0;
    logic glock, glock_req;
    int n_errors = 0, compares = 0;
    fpi_row_s rows [7] = '{
        '{32'h5, 32'h7, fpi_pkg::OPC_ADD, 32'hc}, '{32'hffffffff, 32'h1, fpi_pkg::OPC_ADD, 32'h0},
        '{32'h3, 32'h3, fpi_pkg::OPC_EQ, 32'h1}, '{32'h3, 32'h4, fpi_pkg::OPC_EQ, 32'h0},
        '{32'h80000000, 32'h1, fpi_pkg::OPC_GT, 32'h1}, '{32'h1, 32'h2, fpi_pkg::OPC_GT, 32'h0},
        '{32'h5, 32'h7, fpi_pkg::OPC_SUB, 32'hfffffffe}};

    fpi_function_unit dut (.clk(clk), .rst_n(rst_n), .t1data(t1data), .t1opcode(t1opcode),
        .t1load(t1load), .o1data(o1data), .o1load(o1load), .r1data(r1data), .glock(glock),
        .glock_req(glock_req), .ext_ready(ext_ready));
    fpi_global_control_unit_model core_ctrl (.clk(clk), .rst_n(rst_n), .glock_req(glock_req),
        .hold_lock(hold_lock), .glock(glock));

    always #2 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // drive one cycle of operand and trigger strobes
    task automatic send(input logic [31:0] o1, input logic o1l, input logic [31:0] t1,
        input logic t1l, input logic [1:0] opc);
        o1data = o1;
        o1load = o1l;
        t1data = t1;
        t1load = t1l;
        t1opcode = opc;
        cyc(1);
    endtask

    task automatic test_done;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        rst_n = 1'b1;
        `CHK(r1data, 32'h0)
        `CHK(glock_req, 1'b0)
        $display("test reset done");
        // back-to-back triggers, each result one edge later
        foreach (rows[i]) begin
            send(rows[i].o1, 1'b1, rows[i].t1, 1'b1, rows[i].opc);
            if (i > 0) `CHK(r1data, rows[i-1].res)
        end
        send(32'h0, 1'b0, 32'h0, 1'b0, 2'h0);
        `CHK(r1data, rows[6].res)
        $display("test table done");
        // trigger uses the stored operand, not the idle line
        send(32'h64, 1'b1, 32'h0, 1'b0, 2'h0);
        send(32'hdead, 1'b0, 32'h1, 1'b1, fpi_pkg::OPC_SUB);
        send(32'h0, 1'b0, 32'h0, 1'b0, 2'h0);
        `CHK(r1data, 32'h63)
        $display("test stored operand done");
        // lock freezes a running op and refuses new loads
        hold_lock = 1'b1;
        send(32'h3, 1'b1, 32'h4, 1'b1, fpi_pkg::OPC_ADD);
        send(32'ha, 1'b1, 32'ha, 1'b1, fpi_pkg::OPC_ADD);
        send(32'h0, 1'b0, 32'h0, 1'b0, 2'h0);
        `CHK(r1data, 32'h63)
        hold_lock = 1'b0;
        cyc(2);
        `CHK(r1data, 32'h7)
        send(32'h0, 1'b0, 32'h1, 1'b1, fpi_pkg::OPC_ADD);
        send(32'h0, 1'b0, 32'h0, 1'b0, 2'h0);
        `CHK(r1data, 32'h4)
        $display("test lock done");
        // late result raises the lock request until data arrives
        ext_ready = 1'b0;
        send(32'h5, 1'b1, 32'h6, 1'b1, fpi_pkg::OPC_ADD);
        send(32'h0, 1'b0, 32'h0, 1'b0, 2'h0);
        `WAIT(glock_req === 1'b1)
        cyc(4);
        `CHK(glock_req, 1'b1)
        `CHK(r1data, 32'h4)
        ext_ready = 1'b1;
        `WAIT(glock_req === 1'b0)
        `WAIT(r1data === 32'hb)
        `CHK(r1data, 32'hb)
        $display("test stall done");
        // reset in mid-run clears result and stored operand
        rst_n = 1'b0;
        #1;
        `CHK(r1data, 32'h0)
        cyc(1);
        rst_n = 1'b1;
        send(32'h0, 1'b0, 32'h9, 1'b1, fpi_pkg::OPC_ADD);
        send(32'h0, 1'b0, 32'h0, 1'b0, 2'h0);
        `CHK(r1data, 32'h9)
        $display("test mid reset done");
        test_done();
    end
endmodule

`default_nettype wire
